// File: src/dsgate_pkg.sv
// Register map, field positions and codes for the deep-sleep gate and soft reset block
// Assumes a 32-bit AXI4-Lite register bus with word-aligned byte addresses
package dsgate_pkg;
  localparam logic [11:0] SOFT_RESET_CTRL_ZERO_OFS = 12'h040;
  localparam logic [11:0] DEEP_SLEEP_PORT_GATE_OFS = 12'h128;
  localparam logic [11:0] RUN_PORT_GATE_OFS        = 12'h300;
  localparam logic [11:0] SLEEP_PORT_GATE_OFS      = 12'h304;
  localparam logic [11:0] RUN_CLOCK_CONFIG_OFS     = 12'h308;
  localparam logic [11:0] CAPABILITY_MASK_ONE_OFS  = 12'h30c;
  localparam logic [11:0] IRQ_STATUS_OFS           = 12'h310;
  localparam logic [11:0] IRQ_MASK_OFS             = 12'h314;
  localparam logic [11:0] PORT_BASE_OFS            = 12'h800;
  localparam int          PORT_COUNT               = 8;
  localparam int          PORT_IDX_LSB             = 8;
  localparam int          AUTO_GATE_SELECT_BIT     = 27;
  localparam int          FIELDBUS_RESET_BIT       = 24;
  localparam int          PWM_RESET_BIT            = 20;
  localparam int          WATCHDOG_RESET_BIT       = 3;
  localparam logic [31:0] SOFT_RESET_IMPL_MASK     = 32'h0110_0008;
  localparam logic [31:0] SOFT_RESET_RESET_VAL     = 32'h0000_0000;
  localparam logic [7:0]  GATE_RESET_VAL           = 8'h00;
  localparam logic [31:0] RUN_CLOCK_CONFIG_RESET   = 32'h0000_0000;
  localparam logic [31:0] CAPABILITY_RESET_VAL     = 32'hffff_ffff;
  localparam int          IRQ_FAULT_BIT            = 0;
  localparam int          IRQ_MODE_BIT             = 1;
  localparam logic [1:0]  RESP_OKAY                = 2'h0;
  localparam logic [1:0]  RESP_SLVERR              = 2'h2;
  localparam logic [1:0]  RESP_DECERR              = 2'h3;
  typedef enum logic [1:0] {MODE_RUN, MODE_SLEEP, MODE_DEEP} power_mode_t;
endpackage : dsgate_pkg

// File: src/dsgate_soft_reset.sv
// Deep-sleep port clock gating plus first software reset control, AXI4-Lite slave
// Assumes power mode inputs come from the power controller on the same clock
//
// How it works
// R1: Each deep-sleep gate bit is the clock enable of one port while in deep-sleep.
// R2: An access to a port window whose clock is off gets an error response.
// R3: All gate bits are zero after reset so every port starts unclocked.
// R4: Run, sleep and deep-sleep gate registers apply in their own power modes.
// R5: Sleep and deep-sleep gating apply only with auto gate select set, else run gating.
// R6: Gate bits 31:8 are read-only zero; software keeps them across read-modify-write.
// R7: Gate bit 0 is port A up to bit 7 for port H, all read-write.
// R8: Soft reset writes land only where the capability register has a one.
// R9: Soft reset bit 24 resets the fieldbus controller.
// R10: Soft reset bit 20 resets the PWM module.
// R11: Soft reset bit 3 resets the watchdog; other bits read zero.
// R12: The soft reset register is all zero after reset.
// R13: A set soft reset bit holds its unit in reset until cleared.
`timescale 1ns/1ps
module dsgate_soft_reset (
  input  wire logic        CLOCK,
  input  wire logic        RST_N,
  input  wire logic [11:0] AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [11:0] ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  input  wire logic        SLEEP_REQ,
  input  wire logic        DEEP_SLEEP_REQ,
  output logic [7:0]       PORT_CLK_EN,
  output logic             FIELDBUS_RESET,
  output logic             PWM_RESET,
  output logic             WATCHDOG_RESET,
  output logic             IRQ
);
  logic [11:0] aw_addr_r, aw_addr_nxt;
  logic        aw_have_r, aw_have_nxt;
  logic [31:0] w_data_r, w_data_nxt;
  logic [3:0]  w_strb_r, w_strb_nxt;
  logic        w_have_r, w_have_nxt;
  logic        bvalid_r, bvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt;
  logic        rvalid_r, rvalid_nxt;
  logic [1:0]  rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [7:0]  run_gate_r, run_gate_nxt;
  logic [7:0]  sleep_gate_r, sleep_gate_nxt;
  logic [7:0]  deep_gate_r, deep_gate_nxt;
  logic [31:0] rcc_r, rcc_nxt;
  logic [31:0] cap_r, cap_nxt;
  logic [31:0] srst_r, srst_nxt;
  logic [1:0]  irq_stat_r, irq_stat_nxt;
  logic [1:0]  irq_mask_r, irq_mask_nxt;
  logic [7:0]  port_store_r [8];
  logic [7:0]  port_store_nxt [8];
  logic [7:0]  active_gate;
  logic        do_write;
  logic        do_read;
  logic [31:0] wr_val;
  logic        wr_fault;
  logic        rd_fault;
  logic [1:0]  irq_set;
  dsgate_pkg::power_mode_t mode_r, mode_nxt;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // Mode tracking and gate selection
  always_comb begin
    mode_nxt = dsgate_pkg::MODE_RUN;
    if (DEEP_SLEEP_REQ) begin
      mode_nxt = dsgate_pkg::MODE_DEEP;
    end else if (SLEEP_REQ) begin
      mode_nxt = dsgate_pkg::MODE_SLEEP;
    end
  end

  always_comb begin
    // R4 R5: auto gate select picks sleep registers
    case (mode_r)
      dsgate_pkg::MODE_RUN:   active_gate = run_gate_r;
      dsgate_pkg::MODE_SLEEP: active_gate = rcc_r[dsgate_pkg::AUTO_GATE_SELECT_BIT] ? sleep_gate_r : run_gate_r;
      dsgate_pkg::MODE_DEEP:  active_gate = rcc_r[dsgate_pkg::AUTO_GATE_SELECT_BIT] ? deep_gate_r : run_gate_r;
      default:                active_gate = run_gate_r;
    endcase
  end

  assign do_write = aw_have_r && w_have_r && !bvalid_r;
  assign do_read  = ARVALID && !rvalid_r;
  assign wr_val   = merge(32'h0000_0000, w_data_r, w_strb_r);
  // R2 gated port faults
  assign wr_fault = (aw_addr_r[11:11] == 1'b1) && !active_gate[aw_addr_r[10:8]];
  assign rd_fault = (ARADDR[11:11] == 1'b1) && !active_gate[ARADDR[10:8]];

  always_comb begin
    aw_addr_nxt    = aw_addr_r;
    aw_have_nxt    = aw_have_r;
    w_data_nxt     = w_data_r;
    w_strb_nxt     = w_strb_r;
    w_have_nxt     = w_have_r;
    bvalid_nxt     = bvalid_r;
    bresp_nxt      = bresp_r;
    rvalid_nxt     = rvalid_r;
    rresp_nxt      = rresp_r;
    rdata_nxt      = rdata_r;
    run_gate_nxt   = run_gate_r;
    sleep_gate_nxt = sleep_gate_r;
    deep_gate_nxt  = deep_gate_r;
    rcc_nxt        = rcc_r;
    cap_nxt        = cap_r;
    srst_nxt       = srst_r;
    irq_mask_nxt   = irq_mask_r;
    irq_set        = 2'h0;
    irq_set[dsgate_pkg::IRQ_MODE_BIT] = (mode_nxt != mode_r);
    port_store_nxt = port_store_r;
    if (AWVALID && !aw_have_r) begin
      aw_addr_nxt = AWADDR;
      aw_have_nxt = 1'b1;
    end
    if (WVALID && !w_have_r) begin
      w_data_nxt = WDATA;
      w_strb_nxt = WSTRB;
      w_have_nxt = 1'b1;
    end
    if (bvalid_r && BREADY) begin
      bvalid_nxt = 1'b0;
    end
    if (rvalid_r && RREADY) begin
      rvalid_nxt = 1'b0;
    end
    if (do_write) begin
      aw_have_nxt = 1'b0;
      w_have_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = dsgate_pkg::RESP_OKAY;
      if (aw_addr_r[11]) begin
        if (wr_fault) begin
          bresp_nxt = dsgate_pkg::RESP_SLVERR;
          irq_set[dsgate_pkg::IRQ_FAULT_BIT] = 1'b1;
        end else begin
          port_store_nxt[aw_addr_r[10:8]] = 8'(merge({24'h0, port_store_r[aw_addr_r[10:8]]}, w_data_r, w_strb_r));
        end
      end else begin
        case (aw_addr_r)
          // R6 R7: only bits 7:0 stored
          dsgate_pkg::DEEP_SLEEP_PORT_GATE_OFS: deep_gate_nxt = 8'(merge({24'h0, deep_gate_r}, w_data_r, w_strb_r));
          dsgate_pkg::RUN_PORT_GATE_OFS:        run_gate_nxt = 8'(merge({24'h0, run_gate_r}, w_data_r, w_strb_r));
          dsgate_pkg::SLEEP_PORT_GATE_OFS:      sleep_gate_nxt = 8'(merge({24'h0, sleep_gate_r}, w_data_r, w_strb_r));
          dsgate_pkg::RUN_CLOCK_CONFIG_OFS:     rcc_nxt = merge(rcc_r, w_data_r, w_strb_r);
          dsgate_pkg::CAPABILITY_MASK_ONE_OFS:  cap_nxt = merge(cap_r, w_data_r, w_strb_r);
          // R8 R11: capability and implemented-bit masking
          dsgate_pkg::SOFT_RESET_CTRL_ZERO_OFS: srst_nxt = (srst_r & ~(cap_r & dsgate_pkg::SOFT_RESET_IMPL_MASK))
                                                 | (merge(srst_r, w_data_r, w_strb_r) & cap_r
                                                    & dsgate_pkg::SOFT_RESET_IMPL_MASK);
          dsgate_pkg::IRQ_STATUS_OFS:           ;
          dsgate_pkg::IRQ_MASK_OFS:             irq_mask_nxt = 2'(merge({30'h0, irq_mask_r}, w_data_r, w_strb_r));
          default:                              bresp_nxt = dsgate_pkg::RESP_DECERR;
        endcase
      end
    end
    if (do_read) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = dsgate_pkg::RESP_OKAY;
      rdata_nxt  = 32'h0000_0000;
      if (ARADDR[11]) begin
        if (rd_fault) begin
          rresp_nxt = dsgate_pkg::RESP_SLVERR;
          irq_set[dsgate_pkg::IRQ_FAULT_BIT] = 1'b1;
        end else begin
          rdata_nxt = {24'h0, port_store_r[ARADDR[10:8]]};
        end
      end else begin
        case (ARADDR)
          // R6 upper bits zero
          dsgate_pkg::DEEP_SLEEP_PORT_GATE_OFS: rdata_nxt = {24'h0, deep_gate_r};
          dsgate_pkg::RUN_PORT_GATE_OFS:        rdata_nxt = {24'h0, run_gate_r};
          dsgate_pkg::SLEEP_PORT_GATE_OFS:      rdata_nxt = {24'h0, sleep_gate_r};
          dsgate_pkg::RUN_CLOCK_CONFIG_OFS:     rdata_nxt = rcc_r;
          dsgate_pkg::CAPABILITY_MASK_ONE_OFS:  rdata_nxt = cap_r;
          dsgate_pkg::SOFT_RESET_CTRL_ZERO_OFS: rdata_nxt = srst_r;
          dsgate_pkg::IRQ_STATUS_OFS:           rdata_nxt = {30'h0, irq_stat_r};
          dsgate_pkg::IRQ_MASK_OFS:             rdata_nxt = {30'h0, irq_mask_r};
          default:                              rresp_nxt = dsgate_pkg::RESP_DECERR;
        endcase
      end
    end
    // Set wins over write-one clear
    irq_stat_nxt = irq_stat_r;
    if (do_write && aw_addr_r == dsgate_pkg::IRQ_STATUS_OFS) begin
      irq_stat_nxt = irq_stat_r & ~wr_val[1:0];
    end
    irq_stat_nxt = irq_stat_nxt | irq_set;
  end

  // Bus channels and configuration
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      aw_addr_r    <= 12'h000;
      aw_have_r    <= 1'b0;
      w_data_r     <= 32'h0000_0000;
      w_strb_r     <= 4'h0;
      w_have_r     <= 1'b0;
      bvalid_r     <= 1'b0;
      bresp_r      <= 2'h0;
      rvalid_r     <= 1'b0;
      rresp_r      <= 2'h0;
      rdata_r      <= 32'h0000_0000;
      // R3 gates start off
      run_gate_r   <= dsgate_pkg::GATE_RESET_VAL;
      sleep_gate_r <= dsgate_pkg::GATE_RESET_VAL;
      deep_gate_r  <= dsgate_pkg::GATE_RESET_VAL;
      rcc_r        <= dsgate_pkg::RUN_CLOCK_CONFIG_RESET;
      cap_r        <= dsgate_pkg::CAPABILITY_RESET_VAL;
      // R12 soft reset clear
      srst_r       <= dsgate_pkg::SOFT_RESET_RESET_VAL;
    end else begin
      aw_addr_r    <= aw_addr_nxt;
      aw_have_r    <= aw_have_nxt;
      w_data_r     <= w_data_nxt;
      w_strb_r     <= w_strb_nxt;
      w_have_r     <= w_have_nxt;
      bvalid_r     <= bvalid_nxt;
      bresp_r      <= bresp_nxt;
      rvalid_r     <= rvalid_nxt;
      rresp_r      <= rresp_nxt;
      rdata_r      <= rdata_nxt;
      run_gate_r   <= run_gate_nxt;
      sleep_gate_r <= sleep_gate_nxt;
      deep_gate_r  <= deep_gate_nxt;
      rcc_r        <= rcc_nxt;
      cap_r        <= cap_nxt;
      srst_r       <= srst_nxt;
    end
  end

  // Power mode register
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      mode_r <= dsgate_pkg::MODE_RUN;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // Interrupt status and mask
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      irq_stat_r <= 2'h0;
      irq_mask_r <= 2'h0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
    end
  end

  // Per-port scratch bytes behind the gates
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      for (int p = 0; p < dsgate_pkg::PORT_COUNT; p++) begin
        port_store_r[p] <= 8'h00;
      end
    end else begin
      port_store_r <= port_store_nxt;
    end
  end

  assign AWREADY = !aw_have_r;
  assign WREADY  = !w_have_r;
  assign ARREADY = !rvalid_r;
  assign BVALID  = bvalid_r;
  assign BRESP   = bresp_r;
  assign RVALID  = rvalid_r;
  assign RRESP   = rresp_r;
  assign RDATA   = rdata_r;
  // R1 per-port clock enables
  assign PORT_CLK_EN = active_gate;
  // R13 R9 R10 R11: unit reset holds
  assign FIELDBUS_RESET = srst_r[dsgate_pkg::FIELDBUS_RESET_BIT];
  assign PWM_RESET      = srst_r[dsgate_pkg::PWM_RESET_BIT];
  assign WATCHDOG_RESET = srst_r[dsgate_pkg::WATCHDOG_RESET_BIT];
  assign IRQ            = |(irq_stat_r & irq_mask_r);
endmodule : dsgate_soft_reset

// File: tb/dsgate_soft_reset_asserts.sv
// Checker for fault responses, reset state and unit reset read-back
// Assumes binding to dsgate_soft_reset, one clock domain
`timescale 1ns/1ps
module dsgate_soft_reset_asserts (
  input wire logic        CLOCK,
  input wire logic        RST_N,
  input wire logic [11:0] AWADDR,
  input wire logic        AWVALID,
  input wire logic        AWREADY,
  input wire logic [1:0]  BRESP,
  input wire logic        BVALID,
  input wire logic [11:0] ARADDR,
  input wire logic        ARVALID,
  input wire logic        ARREADY,
  input wire logic [31:0] RDATA,
  input wire logic [1:0]  RRESP,
  input wire logic        RVALID,
  input wire logic [7:0]  PORT_CLK_EN,
  input wire logic        FIELDBUS_RESET,
  input wire logic        PWM_RESET,
  input wire logic        WATCHDOG_RESET
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  wire logic rd_take = ARVALID && ARREADY;
  wire logic rd_port = rd_take && ARADDR[11];
  wire logic wr_port = AWVALID && AWREADY && AWADDR[11];
  property p_rd_fault; rd_port && !PORT_CLK_EN[ARADDR[10:8]] |=> RVALID && RRESP == 2'h2; endproperty
  a_rd_fault: assert property (p_rd_fault) else $error("gated read not faulted");
  property p_rd_ok; rd_port && PORT_CLK_EN[ARADDR[10:8]] |=> RVALID && RRESP == 2'h0; endproperty
  a_rd_ok: assert property (p_rd_ok) else $error("clocked read faulted");
  property p_wr_fault; wr_port && !PORT_CLK_EN[AWADDR[10:8]] |-> ##[1:4] BVALID && BRESP == 2'h2; endproperty
  a_wr_fault: assert property (p_wr_fault) else $error("gated write not faulted");
  property p_wr_ok; wr_port && PORT_CLK_EN[AWADDR[10:8]] |-> ##[1:4] BVALID && BRESP == 2'h0; endproperty
  a_wr_ok: assert property (p_wr_ok) else $error("clocked write faulted");
  property p_rd_ans; rd_take |=> RVALID; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_init; $rose(RST_N) |-> PORT_CLK_EN == 8'h00 && !FIELDBUS_RESET && !PWM_RESET && !WATCHDOG_RESET; endproperty
  a_init: assert property (p_init) else $error("outputs not clear after reset");
  property p_gate_rsvd; rd_take && ARADDR == 12'h128 |=> RDATA[31:8] == 24'h0; endproperty
  a_gate_rsvd: assert property (p_gate_rsvd) else $error("gate upper bits not zero");
  property p_sr_read; rd_take && ARADDR == 12'h040 |=>
    RDATA == {7'h0, FIELDBUS_RESET, 3'h0, PWM_RESET, 16'h0, WATCHDOG_RESET, 3'h0}; endproperty
  a_sr_read: assert property (p_sr_read) else $error("soft reset read mismatch");
endmodule : dsgate_soft_reset_asserts

bind dsgate_soft_reset dsgate_soft_reset_asserts u_chk (.CLOCK(CLOCK), .RST_N(RST_N), .AWADDR(AWADDR),
  .AWVALID(AWVALID), .AWREADY(AWREADY), .BRESP(BRESP), .BVALID(BVALID), .ARADDR(ARADDR), .ARVALID(ARVALID),
  .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .PORT_CLK_EN(PORT_CLK_EN),
  .FIELDBUS_RESET(FIELDBUS_RESET), .PWM_RESET(PWM_RESET), .WATCHDOG_RESET(WATCHDOG_RESET));

// File: tb/tb_top.sv
// Self-checking bench: AXI4-Lite traffic compared with a bench model
// Assumes the checker file binds itself to the design
`timescale 1ns/1ps
module tb_top;
  logic        CLOCK = 1'b0;
  logic        RST_N = 1'b0;
  logic [11:0] AWADDR = 12'h0;
  logic [11:0] ARADDR = 12'h0;
  logic [31:0] WDATA = 32'h0;
  logic [3:0]  WSTRB = 4'hf;
  logic        AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
  logic        SLEEP_REQ = 1'b0, DEEP_SLEEP_REQ = 1'b0;
  logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, FIELDBUS_RESET, PWM_RESET, WATCHDOG_RESET, IRQ;
  logic [1:0]  BRESP, RRESP;
  logic [31:0] RDATA, m_sr, m_cap, m_dg, m_rg, m_sg, m_rcc, d;
  logic [7:0]  PORT_CLK_EN, g;
  int          num_errors = 0, n_checks = 0, cycles = 0, seed = 32'hf37bc10f;

  dsgate_soft_reset dut (.CLOCK(CLOCK), .RST_N(RST_N), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
    .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
    .RVALID(RVALID), .RREADY(RREADY), .SLEEP_REQ(SLEEP_REQ), .DEEP_SLEEP_REQ(DEEP_SLEEP_REQ),
    .PORT_CLK_EN(PORT_CLK_EN), .FIELDBUS_RESET(FIELDBUS_RESET), .PWM_RESET(PWM_RESET),
    .WATCHDOG_RESET(WATCHDOG_RESET), .IRQ(IRQ));

  always #50 CLOCK = ~CLOCK;
  always @(posedge CLOCK) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      conclude();
    end
  end

  task automatic conclude();
    $display("Checks %0d, errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // Observe at the falling edge, act by NBA at the rising edge
  task automatic wchk(input logic [11:0] a, input logic [31:0] dv, input logic [1:0] er);
    logic aw, w, b;
    logic [1:0] rs;
    @(posedge CLOCK);
    AWADDR <= a;
    WDATA <= dv;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do begin
      @(negedge CLOCK);
      aw = AWVALID && AWREADY;
      w = WVALID && WREADY;
      b = BVALID;
      rs = BRESP;
      @(posedge CLOCK);
      if (aw) AWVALID <= 1'b0;
      if (w) WVALID <= 1'b0;
    end while (!b);
    BREADY <= 1'b0;
    chk("write response", {30'h0, er}, {30'h0, rs});
  endtask : wchk

  task automatic rchk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ar, rv;
    logic [31:0] dv;
    logic [1:0] rs;
    @(posedge CLOCK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do begin
      @(negedge CLOCK);
      ar = ARVALID && ARREADY;
      rv = RVALID;
      dv = RDATA;
      rs = RRESP;
      @(posedge CLOCK);
      if (ar) ARVALID <= 1'b0;
    end while (!rv);
    RREADY <= 1'b0;
    chk("read response", {30'h0, er}, {30'h0, rs});
    if (er == 2'h0) chk("read data", e, dv);
  endtask : rchk

  function automatic logic [7:0] gate_exp();
    if (m_rcc[27] && DEEP_SLEEP_REQ) return m_dg[7:0];
    if (m_rcc[27] && SLEEP_REQ) return m_sg[7:0];
    return m_rg[7:0];
  endfunction : gate_exp

  task automatic outs_chk();
    @(negedge CLOCK);
    chk("port enables", {24'h0, gate_exp()}, {24'h0, PORT_CLK_EN});
    chk("unit resets", {29'h0, m_sr[24], m_sr[20], m_sr[3]}, {29'h0, FIELDBUS_RESET, PWM_RESET, WATCHDOG_RESET});
  endtask : outs_chk

  task automatic do_reset();
    RST_N <= 1'b0;
    repeat (10) @(posedge CLOCK);
    RST_N <= 1'b1;
    m_sr = 32'h0;
    m_cap = 32'hffff_ffff;
    m_dg = 32'h0;
    m_rg = 32'h0;
    m_sg = 32'h0;
    m_rcc = 32'h0;
  endtask : do_reset

  initial begin
    do_reset();
    rchk(12'h040, 32'h0, 2'h0);
    rchk(12'h128, 32'h0, 2'h0);
    outs_chk();
    for (int i = 0; i < 12; i++) begin
      d = $random(seed);
      m_cap = (i < 6) ? 32'hffff_ffff : $random(seed);
      wchk(12'h30c, m_cap, 2'h0);
      wchk(12'h040, d, 2'h0);
      m_sr = (m_sr & ~(m_cap & 32'h0110_0008)) | (d & m_cap & 32'h0110_0008);
      rchk(12'h040, m_sr, 2'h0);
      outs_chk();
    end
    for (int i = 0; i < 8; i++) begin
      m_dg = $random(seed);
      m_rg = $random(seed);
      m_sg = $random(seed);
      m_rcc = i[0] ? 32'h0800_0000 : 32'h0;
      wchk(12'h128, m_dg, 2'h0);
      wchk(12'h300, m_rg, 2'h0);
      wchk(12'h304, m_sg, 2'h0);
      wchk(12'h308, m_rcc, 2'h0);
      SLEEP_REQ <= i[1];
      DEEP_SLEEP_REQ <= i[2];
      rchk(12'h128, m_dg & 32'hff, 2'h0);
      outs_chk();
    end
    @(posedge CLOCK);
    WSTRB <= 4'he;
    wchk(12'h128, ~m_dg, 2'h0);
    WSTRB <= 4'hf;
    rchk(12'h128, m_dg & 32'hff, 2'h0);
    @(negedge CLOCK);
    chk("irq masked", 32'h0, {31'h0, IRQ});
    wchk(12'h314, 32'h1, 2'h0);
    rchk(12'h310, 32'h2, 2'h0);
    wchk(12'h310, 32'h3, 2'h0);
    g = gate_exp();
    for (int p = 0; p < 8; p++) begin
      d = $random(seed);
      wchk(12'h800 + 12'(p * 256), d, g[p] ? 2'h0 : 2'h2);
      rchk(12'h800 + 12'(p * 256), d & 32'hff, g[p] ? 2'h0 : 2'h2);
    end
    @(negedge CLOCK);
    chk("irq raised", {31'h0, g != 8'hff}, {31'h0, IRQ});
    wchk(12'h310, 32'h1, 2'h0);
    @(negedge CLOCK);
    chk("irq cleared", 32'h0, {31'h0, IRQ});
    rchk(12'h004, 32'h0, 2'h3);
    do_reset();
    rchk(12'h040, 32'h0, 2'h0);
    outs_chk();
    conclude();
  end
endmodule : tb_top
